// *** pkg/mmpc_defs.svh ***
// Register offsets, field positions, reset values and timing figures of the pulse counter
`ifndef MMPC_DEFS_SVH
`define MMPC_DEFS_SVH

// Register byte offsets
`define MMPC_OFF_CTRL 6'h00
`define MMPC_OFF_CMD 6'h04
`define MMPC_OFF_PRESET 6'h08
`define MMPC_OFF_MODULO 6'h0C
`define MMPC_OFF_COUNT 6'h10
`define MMPC_OFF_STATUS 6'h14
`define MMPC_OFF_FREQ 6'h18
`define MMPC_OFF_EVENTS 6'h1C
`define MMPC_OFF_INTERVAL 6'h20
`define MMPC_OFF_PWM_PERIOD 6'h24
`define MMPC_OFF_PWM_HIGH 6'h28

// Control register fields
`define MMPC_CTRL_MODE_LSB 0
`define MMPC_CTRL_MODE_MSB 2
`define MMPC_CTRL_ENABLE 4
`define MMPC_CTRL_AUX_GATE 5
`define MMPC_CTRL_VARIANT8 6
`define MMPC_CTRL_OUT1 7

// Command register fields
`define MMPC_CMD_VALID_SYNC 0
`define MMPC_CMD_FORCE_ENABLE 1

// Status register fields
`define MMPC_STAT_DONE 0
`define MMPC_STAT_WRAP 1

// Reset values
`define MMPC_RST_WORD 32'h0000_0000
`define MMPC_RST_INTERVAL 32'h0000_0001
`define MMPC_ONE 32'h0000_0001

// Timing figures in their own units
`define MMPC_CLK_HZ 200000000
`define MMPC_TICK_MS 1
`define MMPC_GATE_MS 1000
`define MMPC_BLANK_MS 100
`define MMPC_EVT_MIN_US 50
`define MMPC_PWM_MAX_HZ 4000

`endif

// *** pkg/mmpc_pkg.sv ***
// Types shared by the pulse counter modules
package mmpc_pkg;

  typedef enum logic [2:0] {
    MMPC_DOWN,
    MMPC_MODULO,
    MMPC_CNT32,
    MMPC_FREQ,
    MMPC_EVENT,
    MMPC_PWM,
    MMPC_IDLE6,
    MMPC_IDLE7
  } mmpc_mode_t;

  typedef struct packed {
    logic prev;
    logic [31:0] high_cnt;
    logic fired;
    logic rise;
    logic fall;
  } mmpc_filt_t;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    mmpc_mode_t mode;
    logic enable;
    logic aux_gate;
    logic variant8;
    logic out1;
    logic valid_sync;
    logic force_enable;
    logic [31:0] preset;
    logic [31:0] modulo;
    logic [31:0] interval;
    logic [31:0] pwm_period;
    logic [31:0] pwm_high;
    logic [31:0] count;
    logic [31:0] count_vis;
    logic [31:0] freq;
    logic [31:0] events;
    logic [31:0] acc;
    logic done;
    logic wrap;
    logic [31:0] ms_div;
    logic [31:0] win_ms;
    logic [31:0] blank_ms;
    logic [31:0] pwm_cnt;
    logic out0;
  } mmpc_state_t;

endpackage

// *** rtl/mmpc_core.sv ***
// Multi-mode pulse counter channel with Avalon-MM register slave
//
// Behaviour
// - Downcount: sync event loads preset, count pulses decrement it down to zero.
// - Outside eight-channel mode, downcount pulses change the counter only while enable is active.
// - Visible count register refreshes once per millisecond while downcounting.
// - Preset register is a full 32-bit unsigned value.
// - Downcount counter holds values up to 4,294,967,295.
// - Modulo up: count to modulo minus one, then wrap to zero.
// - Modulo down: count to zero, then reload modulo minus one.
// - Modulo setting zero means full 32-bit wrap.
// - 32-bit mode counter is signed two's complement.
// - Width modulation drives only the modulated output; second output independent.
// - Modulation frequency capped at 4 kHz; duty range follows period.
// - Frequency mode reports first input pulse rate in hertz, 1 Hz resolution.
// - Event mode counts first input pulses per user-set interval.
// - Auxiliary input gates event counting only when its enable is configured.
// - Eight-channel event pulses count only when longer than 50 us.
// - Eight-channel event pulses within 100 ms of sync are dropped.
// - Eight-channel downcount: aux edge loads preset once validated; decrement needs force-enable.
`timescale 1ns/100ps
`default_nettype none
`include "mmpc_defs.svh"
module mmpc_core
  import mmpc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MMPC_CLK_HZ / 1000 * `MMPC_TICK_MS,
  parameter int unsigned EVT_MIN_CYCLES = `MMPC_CLK_HZ / 1000000 * `MMPC_EVT_MIN_US,
  parameter int unsigned PWM_MIN_PERIOD = `MMPC_CLK_HZ / `MMPC_PWM_MAX_HZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Field inputs
  input wire logic in_a,
  input wire logic in_b,
  input wire logic in_sync,
  input wire logic in_aux,
  // Field outputs
  output logic modulated_output,
  output logic second_output,
  output logic done_flag
);
  import mmpc_pkg::*;

  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);
  localparam logic [31:0] EVT_MIN = 32'(EVT_MIN_CYCLES);
  localparam logic [31:0] PWM_MIN = 32'(PWM_MIN_PERIOD);
  localparam logic [31:0] GATE_LAST = 32'(`MMPC_GATE_MS - 1);
  localparam logic [31:0] BLANK_LEN = 32'(`MMPC_BLANK_MS);

  mmpc_state_t s;
  mmpc_state_t next_s;

  logic a_rise;
  logic b_rise;
  logic sync_rise;
  logic aux_rise;
  logic aux_fall;
  logic [31:0] a_min;

  // Long-pulse qualification only for eight-channel event counting
  assign a_min = (s.variant8 && s.mode == MMPC_EVENT) ? EVT_MIN : '0;

  mmpc_pulse_filter u_filt_a (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(in_a),
    .min_cycles(a_min),
    .rise(a_rise),
    .fall()
  );

  mmpc_pulse_filter u_filt_b (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(in_b),
    .min_cycles('0),
    .rise(b_rise),
    .fall()
  );

  mmpc_pulse_filter u_filt_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(in_sync),
    .min_cycles('0),
    .rise(sync_rise),
    .fall()
  );

  mmpc_pulse_filter u_filt_aux (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(in_aux),
    .min_cycles('0),
    .rise(aux_rise),
    .fall(aux_fall)
  );

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic ms_tick;
  logic [31:0] mod_last;
  logic [31:0] pwm_per;
  logic [31:0] pwm_hi;
  logic [31:0] win_last;
  logic dn_load;
  logic dn_step;
  logic ev_count;
  logic req;
  logic [31:0] wd;
  logic wrap_set;

  always_comb begin
    next_s = s;
    ms_tick = (s.ms_div == MS_LAST);
    next_s.ms_div = ms_tick ? '0 : s.ms_div + `MMPC_ONE;
    mod_last = s.modulo - `MMPC_ONE;
    pwm_per = (s.pwm_period < PWM_MIN) ? PWM_MIN : s.pwm_period;
    pwm_hi = (s.pwm_high > pwm_per) ? pwm_per : s.pwm_high;
    win_last = (s.interval == '0) ? '0 : s.interval - `MMPC_ONE;
    dn_load = 1'b0;
    dn_step = 1'b0;
    ev_count = 1'b0;
    req = (avs_read || avs_write) && s.waitreq;
    wd = avs_writedata;
    wrap_set = 1'b0;

    // Counting modes
    case (s.mode)
      MMPC_DOWN: begin
        if (s.variant8) begin
          dn_load = s.valid_sync && (aux_rise || aux_fall);
          dn_step = s.force_enable && a_rise;
        end else begin
          dn_load = sync_rise;
          dn_step = s.enable && a_rise;
        end
        if (dn_load) begin
          next_s.count = s.preset;
          next_s.done = (s.preset == '0);
        end else if (dn_step && s.count != '0) begin
          next_s.count = s.count - `MMPC_ONE;
          if (s.count == `MMPC_ONE) begin
            next_s.done = 1'b1;
          end
        end
        if (ms_tick) begin
          next_s.count_vis = next_s.count;
        end
      end
      MMPC_MODULO: begin
        if (a_rise && !b_rise) begin
          if (s.count == mod_last) begin
            next_s.count = '0;
            next_s.wrap = 1'b1;
            wrap_set = 1'b1;
          end else begin
            next_s.count = s.count + `MMPC_ONE;
          end
        end else if (b_rise && !a_rise) begin
          if (s.count == '0) begin
            next_s.count = mod_last;
            next_s.wrap = 1'b1;
            wrap_set = 1'b1;
          end else begin
            next_s.count = s.count - `MMPC_ONE;
          end
        end
        next_s.count_vis = next_s.count;
      end
      MMPC_CNT32: begin
        // Simultaneous up and down pulses cancel; arithmetic wraps in two's complement
        if (sync_rise) begin
          next_s.count = s.preset;
        end else if (a_rise && !b_rise) begin
          next_s.count = 32'($signed(s.count) + 1);
        end else if (b_rise && !a_rise) begin
          next_s.count = 32'($signed(s.count) - 1);
        end
        next_s.count_vis = next_s.count;
      end
      MMPC_FREQ: begin
        if (a_rise) begin
          next_s.acc = s.acc + `MMPC_ONE;
        end
        if (ms_tick) begin
          if (s.win_ms >= GATE_LAST) begin
            // One-second gate gives pulses per second directly
            next_s.freq = s.acc + {31'h0000_0000, a_rise};
            next_s.acc = '0;
            next_s.win_ms = '0;
          end else begin
            next_s.win_ms = s.win_ms + `MMPC_ONE;
          end
        end
      end
      MMPC_EVENT: begin
        ev_count = a_rise && (!s.aux_gate || in_aux);
        if (s.variant8 && s.blank_ms != '0) begin
          ev_count = 1'b0;
        end
        if (ev_count) begin
          next_s.acc = s.acc + `MMPC_ONE;
        end
        if (ms_tick && s.blank_ms != '0) begin
          next_s.blank_ms = s.blank_ms - `MMPC_ONE;
        end
        if (sync_rise) begin
          next_s.acc = '0;
          next_s.win_ms = '0;
          next_s.blank_ms = s.variant8 ? BLANK_LEN : '0;
        end else if (ms_tick) begin
          if (s.win_ms >= win_last) begin
            next_s.events = s.acc + {31'h0000_0000, ev_count};
            next_s.acc = '0;
            next_s.win_ms = '0;
          end else begin
            next_s.win_ms = s.win_ms + `MMPC_ONE;
          end
        end
      end
      MMPC_PWM: begin
        next_s.pwm_cnt = (s.pwm_cnt >= pwm_per - `MMPC_ONE) ? '0 : s.pwm_cnt + `MMPC_ONE;
      end
      default: begin
        next_s.count_vis = s.count_vis;
      end
    endcase

    // Modulated output: waveform in modulation mode, completion flag otherwise
    if (s.mode == MMPC_PWM) begin
      next_s.out0 = (s.pwm_cnt < pwm_hi);
    end else begin
      next_s.out0 = s.done;
    end

    // Register slave: one wait cycle, then data with waitrequest low
    next_s.waitreq = 1'b1;
    if (req) begin
      next_s.waitreq = 1'b0;
      next_s.rdata = '0;
      if (avs_write) begin
        if (avs_address == `MMPC_OFF_CTRL) begin
          if (avs_byteenable[0]) begin
            next_s.mode = mmpc_mode_t'(wd[`MMPC_CTRL_MODE_MSB:`MMPC_CTRL_MODE_LSB]);
            next_s.enable = wd[`MMPC_CTRL_ENABLE];
            next_s.aux_gate = wd[`MMPC_CTRL_AUX_GATE];
            next_s.variant8 = wd[`MMPC_CTRL_VARIANT8];
            next_s.out1 = wd[`MMPC_CTRL_OUT1];
            // Any control write with byte lane 0 enabled restarts the measurement windows
            next_s.acc = '0;
            next_s.win_ms = '0;
            next_s.pwm_cnt = '0;
          end
        end else if (avs_address == `MMPC_OFF_CMD) begin
          if (avs_byteenable[0]) begin
            next_s.valid_sync = wd[`MMPC_CMD_VALID_SYNC];
            next_s.force_enable = wd[`MMPC_CMD_FORCE_ENABLE];
          end
        end else if (avs_address == `MMPC_OFF_PRESET) begin
          next_s.preset = be_merge(s.preset, wd, avs_byteenable);
        end else if (avs_address == `MMPC_OFF_MODULO) begin
          next_s.modulo = be_merge(s.modulo, wd, avs_byteenable);
        end else if (avs_address == `MMPC_OFF_STATUS) begin
          // Write one clears the wrap bit; a wrap in this same cycle wins
          if (avs_byteenable[0] && wd[`MMPC_STAT_WRAP] && !wrap_set) begin
            next_s.wrap = 1'b0;
          end
        end else if (avs_address == `MMPC_OFF_INTERVAL) begin
          next_s.interval = be_merge(s.interval, wd, avs_byteenable);
        end else if (avs_address == `MMPC_OFF_PWM_PERIOD) begin
          next_s.pwm_period = be_merge(s.pwm_period, wd, avs_byteenable);
        end else if (avs_address == `MMPC_OFF_PWM_HIGH) begin
          next_s.pwm_high = be_merge(s.pwm_high, wd, avs_byteenable);
        end
      end else begin
        if (avs_address == `MMPC_OFF_CTRL) begin
          next_s.rdata[`MMPC_CTRL_MODE_MSB:`MMPC_CTRL_MODE_LSB] = s.mode;
          next_s.rdata[`MMPC_CTRL_ENABLE] = s.enable;
          next_s.rdata[`MMPC_CTRL_AUX_GATE] = s.aux_gate;
          next_s.rdata[`MMPC_CTRL_VARIANT8] = s.variant8;
          next_s.rdata[`MMPC_CTRL_OUT1] = s.out1;
        end else if (avs_address == `MMPC_OFF_CMD) begin
          next_s.rdata[`MMPC_CMD_VALID_SYNC] = s.valid_sync;
          next_s.rdata[`MMPC_CMD_FORCE_ENABLE] = s.force_enable;
        end else if (avs_address == `MMPC_OFF_PRESET) begin
          next_s.rdata = s.preset;
        end else if (avs_address == `MMPC_OFF_MODULO) begin
          next_s.rdata = s.modulo;
        end else if (avs_address == `MMPC_OFF_COUNT) begin
          next_s.rdata = s.count_vis;
        end else if (avs_address == `MMPC_OFF_STATUS) begin
          next_s.rdata[`MMPC_STAT_DONE] = s.done;
          next_s.rdata[`MMPC_STAT_WRAP] = s.wrap;
        end else if (avs_address == `MMPC_OFF_FREQ) begin
          next_s.rdata = s.freq;
        end else if (avs_address == `MMPC_OFF_EVENTS) begin
          next_s.rdata = s.events;
        end else if (avs_address == `MMPC_OFF_INTERVAL) begin
          next_s.rdata = s.interval;
        end else if (avs_address == `MMPC_OFF_PWM_PERIOD) begin
          next_s.rdata = s.pwm_period;
        end else if (avs_address == `MMPC_OFF_PWM_HIGH) begin
          next_s.rdata = s.pwm_high;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.mode <= MMPC_DOWN;
      s.interval <= `MMPC_RST_INTERVAL;
      s.preset <= `MMPC_RST_WORD;
      s.modulo <= `MMPC_RST_WORD;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign modulated_output = s.out0;
  assign second_output = s.out1;
  assign done_flag = s.done;
endmodule // mmpc_core
`default_nettype wire

// *** rtl/mmpc_pulse_filter.sv ***
// Edge detector with optional minimum high-time qualification
`timescale 1ns/100ps
`default_nettype none
module mmpc_pulse_filter
  import mmpc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pulse input and qualification length, zero for plain edges
  input wire logic pin,
  input wire logic [31:0] min_cycles,
  // Qualified rising event and falling edge
  output logic rise,
  output logic fall
);
  import mmpc_pkg::*;

  mmpc_filt_t s;
  mmpc_filt_t next_s;

  always_comb begin
    next_s = s;
    next_s.prev = pin;
    next_s.rise = 1'b0;
    next_s.fall = s.prev && !pin;
    if (!pin) begin
      next_s.high_cnt = '0;
      next_s.fired = 1'b0;
    end else if (min_cycles == '0) begin
      next_s.rise = !s.prev;
    end else if (!s.fired) begin
      next_s.high_cnt = s.high_cnt + `MMPC_ONE;
      // Fires only once high time exceeds the minimum
      if (s.high_cnt >= min_cycles) begin
        next_s.rise = 1'b1;
        next_s.fired = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.rise;
  assign fall = s.fall;
endmodule // mmpc_pulse_filter
`default_nettype wire

// *** verification/mmpc_core_asserts.sv ***
// Port-level checks of the pulse counter channel
`timescale 1ns/100ps
`default_nettype none
module mmpc_core_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Field side
  input wire logic in_sync,
  input wire logic in_aux,
  input wire logic modulated_output,
  input wire logic second_output,
  input wire logic done_flag
);
  typedef struct packed {logic [2:0] mode; logic out1;} mmpc_chk_t;
  mmpc_chk_t sh;
  mmpc_chk_t next_sh;
  logic ctrl_take;
  assign ctrl_take = avs_write && avs_waitrequest && avs_address == 6'h00 && avs_byteenable[0];
  // Shadow of the control word as taken on the bus
  always_comb begin
    next_sh = sh;
    if (ctrl_take) begin
      next_sh.mode = avs_writedata[2:0];
      next_sh.out1 = avs_writedata[7];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sh <= '0;
    end else begin
      sh <= next_sh;
    end
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence bus_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence one_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  wait_answer_a: assert property (bus_take |=> one_answer)
    else $error("bus request not answered in one cycle");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
    else $error("answer without a request");
  unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address > 6'h28 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  rd_hold_a: assert property ($past(rst_n) && avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved while idle");
  done_load_a: assert property ($fell(done_flag) && $past(rst_n) |-> $past(in_sync, 2) ||
    $past(in_aux, 2) != $past(in_aux, 3) || $past(avs_write) || $past(avs_write, 2))
    else $error("completion dropped without a load");
  mod_follow_a: assert property ($past(rst_n) && sh.mode != 3'h5 && $past(sh.mode) != 3'h5
    |-> modulated_output == $past(done_flag))
    else $error("output does not follow completion");
  out1_track_a: assert property ($stable(sh.out1) |-> second_output == sh.out1)
    else $error("second output differs from control bit");
  out1_cause_a: assert property ($changed(second_output) && $past(rst_n) |-> $past(avs_write))
    else $error("second output moved without a write");
endmodule // mmpc_core_asserts
bind mmpc_core mmpc_core_asserts mmpc_core_asserts_inst (.core_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .in_sync, .in_aux,
  .modulated_output, .second_output, .done_flag);
`default_nettype wire

// *** verification/mmpc_field_model.sv ***
// Sensor and encoder model driving the counter inputs
`timescale 1ns/100ps
`default_nettype none
module mmpc_field_model #(
  parameter int MS = 10
) (
  // Clock
  input wire logic core_clk,
  // Push-pull pulse lines
  output logic in_a,
  output logic in_b,
  output logic in_sync,
  output logic in_aux
);
  int cyc = 0;
  int last_sync = -1000;
  initial begin
    in_a = 1'b0;
    in_b = 1'b0;
    in_sync = 1'b0;
    in_aux = 1'b0;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  // Pulses on a (bit 0) and b (bit 1), pacing set by caller
  task automatic burst(input int ch, input int n, input int hi, input int lo);
    repeat (n) begin
      in_a <= ch[0];
      in_b <= ch[1];
      repeat (hi) @(posedge core_clk);
      in_a <= 1'b0;
      in_b <= 1'b0;
      repeat (lo) @(posedge core_clk);
    end
  endtask
  task automatic sync_pulse();
    while (cyc - last_sync < 5 * MS) @(posedge core_clk);
    last_sync = cyc;
    in_sync <= 1'b1;
    repeat (MS / 10 + 1) @(posedge core_clk);
    in_sync <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic aux_edge();
    in_aux <= !in_aux;
    repeat (MS) @(posedge core_clk);
  endtask
endmodule // mmpc_field_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the pulse counter channel
`timescale 1ns/100ps
`default_nettype none
`include "mmpc_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import mmpc_pkg::*;
  localparam int MS = 10;
  localparam logic [5:0] ctl = `MMPC_OFF_CTRL;
  localparam logic [5:0] cnt = `MMPC_OFF_COUNT;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic in_a, in_b, in_sync, in_aux, modulated_output, second_output, done_flag;
  logic [31:0] ev_ctrl[5] = '{32'h4, 32'h24, 32'h24, 32'h44, 32'h44};
  int ev_hi[5] = '{10, 10, 10, 5, 12};
  logic [31:0] ev_exp[5] = '{32'h4, 32'h0, 32'h4, 32'h0, 32'h4};
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int seed, n, hc;
  longint r;
  bit up;
  mmpc_core #(.MS_CYCLES(MS), .EVT_MIN_CYCLES(8), .PWM_MIN_PERIOD(10)) mmpc_core_inst (.core_clk, .rst_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .in_a, .in_b, .in_sync, .in_aux, .modulated_output, .second_output, .done_flag);
  mmpc_field_model #(.MS(MS)) fld (.core_clk, .in_a, .in_b, .in_sync, .in_aux);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      complete_run();
    end
  end
  // Reference step of the loop counter
  function automatic longint mstep(longint c, longint m, bit u);
    if (u) return (c + 1 == m) ? 0 : c + 1;
    return (c == 0) ? m - 1 : c - 1;
  endfunction
  task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    `CHK(q, e)
  endtask
  task automatic tick();
    repeat (2 * MS + 2) @(posedge core_clk);
  endtask
  initial begin
    seed = 17242;
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) rd(6'(i * 4), (i == 8) ? `MMPC_RST_INTERVAL : `MMPC_RST_WORD);
    wr(6'h2C, 32'hFFFF_FFFF);
    rd(6'h2C, 32'h0);
    wr(cnt, 32'h5);
    rd(cnt, 32'h0);
    wr(`MMPC_OFF_PRESET, 32'hFFFF_FFFF);
    bus(1'b1, `MMPC_OFF_PRESET, 32'h0, 4'h1);
    rd(`MMPC_OFF_PRESET, 32'hFFFF_FF00);
    wr(ctl, 32'h0);
    fld.sync_pulse();
    fld.burst(1, 2, 2, 3);
    tick();
    rd(cnt, 32'hFFFF_FF00);
    n = 3 + ($random(seed) & 7);
    wr(`MMPC_OFF_PRESET, 32'(n));
    wr(ctl, 32'h10);
    fld.sync_pulse();
    fld.burst(1, n - 1, 2, 3);
    tick();
    rd(cnt, 32'h1);
    `CHK(done_flag, 1'b0)
    fld.burst(1, 3, 2, 3);
    tick();
    rd(cnt, 32'h0);
    `CHK(done_flag, 1'b1)
    wr(`MMPC_OFF_MODULO, 32'h3);
    wr(ctl, 32'h1);
    r = 0;
    for (int i = 0; i < 8; i++) begin
      up = 1'($random(seed));
      fld.burst(up ? 1 : 2, 1, 2, 48);
      r = mstep(r, 3, up);
    end
    fld.burst(1, 3, 2, 48);
    r = mstep(mstep(mstep(r, 3, 1'b1), 3, 1'b1), 3, 1'b1);
    fld.burst(3, 1, 2, 48);
    rd(cnt, 32'(r));
    bus(1'b0, `MMPC_OFF_STATUS, 32'h0, 4'hF);
    `CHK(q[1], 1'b1)
    wr(`MMPC_OFF_STATUS, 32'h2);
    bus(1'b0, `MMPC_OFF_STATUS, 32'h0, 4'hF);
    `CHK(q[1], 1'b0)
    wr(`MMPC_OFF_MODULO, 32'h0);
    fld.burst(2, int'(r) + 1, 2, 48);
    rd(cnt, 32'hFFFF_FFFF);
    fld.burst(1, 1, 2, 48);
    rd(cnt, 32'h0);
    wr(`MMPC_OFF_PRESET, 32'h0);
    wr(ctl, 32'h2);
    fld.sync_pulse();
    fld.burst(2, 3, 2, 3);
    fld.burst(1, 1, 2, 3);
    rd(cnt, 32'hFFFF_FFFE);
    wr(ctl, 32'h3);
    fld.burst(1, 900, 10, 15);
    rd(`MMPC_OFF_FREQ, 32'h190);
    wr(`MMPC_OFF_INTERVAL, 32'hA);
    foreach (ev_ctrl[i]) begin
      if (i == 2) fld.aux_edge();
      wr(ctl, ev_ctrl[i]);
      fld.burst(1, 14, ev_hi[i], 25 - ev_hi[i]);
      rd(`MMPC_OFF_EVENTS, ev_exp[i]);
    end
    fld.sync_pulse();
    fld.burst(1, 14, 12, 13);
    rd(`MMPC_OFF_EVENTS, 32'h0);
    fld.burst(1, 44, 12, 13);
    rd(`MMPC_OFF_EVENTS, 32'h4);
    wr(`MMPC_OFF_PWM_HIGH, 32'h5);
    for (int i = 0; i < 2; i++) begin
      wr(`MMPC_OFF_PWM_PERIOD, i ? 32'h4 : 32'h14);
      wr(ctl, 32'h85);
      hc = 0;
      repeat (200) begin
        @(posedge core_clk);
        hc += (modulated_output === 1'b1);
      end
      `CHK(hc, i ? 100 : 50)
      `CHK(second_output, 1'b1)
    end
    wr(`MMPC_OFF_PRESET, 32'h2);
    wr(ctl, 32'h40);
    wr(`MMPC_OFF_CMD, 32'h1);
    fld.aux_edge();
    fld.burst(1, 1, 2, 3);
    tick();
    rd(cnt, 32'h2);
    wr(`MMPC_OFF_CMD, 32'h3);
    fld.burst(1, 2, 2, 3);
    tick();
    rd(cnt, 32'h0);
    `CHK(done_flag, 1'b1)
    fld.aux_edge();
    `CHK(done_flag, 1'b0)
    tick();
    rd(cnt, 32'h2);
    wr(`MMPC_OFF_CMD, 32'h2);
    fld.burst(1, 1, 2, 3);
    fld.aux_edge();
    tick();
    rd(cnt, 32'h1);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
